// >>> verilog/backlight_dimming_control_defs.vh
// register offsets, field positions, reset values and timing counts
`ifndef BACKLIGHT_DIMMING_CONTROL_DEFS_VH
`define BACKLIGHT_DIMMING_CONTROL_DEFS_VH
`define REG_BL_ENABLE 8'h01
`define REG_DIM_CONFIG 8'h02
`define REG_RAMP_HYST 8'h03
`define REG_BRIGHT_LSB 8'h04
`define REG_BRIGHT_MSB 8'h05
`define REG_SINK_ENABLE 8'h08
`define REG_FB_DISABLE 8'h10
`define REG_DUTY_LOW 8'h12
`define REG_DUTY_HIGH 8'h13
`define REG_ONOFF_RAMP 8'h14
`define REG_FULL_SCALE 8'h15
`define REG_STATUS 8'h16
`define BIT_BL_ON 0
`define BIT_PWM_EN 0
`define BIT_ONOFF_SHAPE 1
`define BIT_PWM_POL 2
`define BIT_MAP_LINEAR 3
`define RST_BL_ENABLE 8'h00
`define RST_DIM_CONFIG 8'h02
`define RST_RAMP_HYST 8'h00
`define RST_BRIGHT_LSB 8'h07
`define RST_BRIGHT_MSB 8'hff
`define RST_SINK_ENABLE 8'hff
`define RST_FB_DISABLE 8'h00
`define RST_ONOFF_RAMP 8'h44
`define RST_FULL_SCALE 8'hf8
`define FULL_DUTY 11'h7ff
`define CLOCK_HZ 20000000
`define RAMP_UNIT_NS 1000
`define RAMP_UNIT_CYC ((`RAMP_UNIT_NS * (`CLOCK_HZ / 1000000)) / 1000)
`define ONOFF_UNIT_US 512
`define ONOFF_UNIT_CYC (`ONOFF_UNIT_US * (`CLOCK_HZ / 1000000))
`endif

// >>> verilog/backlight_dimming_control.v
// eight-channel backlight dimming control logic
`include "backlight_dimming_control_defs.vh"
module backlight_dimming_control #(
	parameter PERIOD_W = 18,
	parameter STEP_SCALE = 1
) (
	input wire CLOCK_I,
	input wire RESET_I,
	input wire HARDWARE_ENABLE_PIN_I,
	input wire PWM_PIN_I,
	input wire [7:0] SINK_GROUNDED_I,
	input wire [7:0] ADDR_I,
	input wire [7:0] WDATA_I,
	input wire WRITE_I,
	input wire READ_I,
	output reg [7:0] RDATA_O,
	output reg [7:0] SINK_ON_O,
	output reg BOOST_ON_O,
	output reg MAPPING_LINEAR_O,
	output reg [4:0] FULL_SCALE_SINK_CURRENT_O,
	output reg [10:0] LEVEL_CODE_O,
	output reg [10:0] LEVEL_DUTY_O
);
	reg en_s1;
	reg en_s2;
	reg pwm_s1;
	reg pwm_s2;
	reg bl_enable;
	reg pwm_en;
	reg pwm_active_low;
	reg map_linear;
	reg onoff_shape;
	reg [7:0] dim_config;
	reg [7:0] ramp_hyst;
	reg [7:0] bright_lsb;
	reg [7:0] bright_msb;
	reg [7:0] sink_enable;
	reg [7:0] fb_disable;
	reg [7:0] onoff_ramp;
	reg [7:0] full_scale;
	reg [7:0] grounded;
	reg [7:0] gnd_s1;
	reg [7:0] gnd_s2;
	reg [10:0] active_code;
	reg [10:0] duty;
	reg [10:0] duty_follow;
	reg [10:0] target;
	reg [10:0] level;
	reg [PERIOD_W-1:0] hi_cnt;
	reg [PERIOD_W-1:0] per_cnt;
	reg pwm_prev;
	reg duty_seen;
	reg dir_up;
	reg start_done;
	reg [31:0] tick;
	reg [31:0] step_cyc;
	wire enabled = en_s2;
	wire [10:0] code_now = active_code;
	wire pwm_level = pwm_s2 ^ pwm_active_low;
	wire pwm_rise = pwm_level & ~pwm_prev;
	wire wr = WRITE_I & enabled;
	wire rd = READ_I & enabled;
	wire [3:0] ramp_sel = ramp_hyst[6:3];
	wire [3:0] hyst_sel = {1'b0, ramp_hyst[2:0]};
	wire [11:0] hyst_lsb = {7'h00, hyst_sel, 1'b0};
	wire [7:0] sinks_use = sink_enable & ~grounded;
	wire all_fb_off = (fb_disable == 8'hff);
	wire bl_wanted = bl_enable & (sinks_use != 8'h00) & (code_now != 11'h000)
		& (~pwm_en | (duty_follow != 11'h000));
	reg [10:0] next_duty;
	reg [PERIOD_W+10:0] prod;
	reg [PERIOD_W+10:0] scaled;

	// input synchronisers
	always @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			en_s1 <= 1'b0;
			en_s2 <= 1'b0;
			pwm_s1 <= 1'b0;
			pwm_s2 <= 1'b0;
		end else begin
			en_s1 <= HARDWARE_ENABLE_PIN_I;
			en_s2 <= en_s1;
			pwm_s1 <= PWM_PIN_I;
			pwm_s2 <= pwm_s1;
		end
	end

	// register writes
	always @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			dim_config <= `RST_DIM_CONFIG;
			bl_enable <= 1'b0;
			ramp_hyst <= `RST_RAMP_HYST;
			bright_lsb <= `RST_BRIGHT_LSB;
			bright_msb <= `RST_BRIGHT_MSB;
			active_code <= {`RST_BRIGHT_MSB, 3'h7};
			sink_enable <= `RST_SINK_ENABLE;
			fb_disable <= `RST_FB_DISABLE;
			onoff_ramp <= `RST_ONOFF_RAMP;
			full_scale <= `RST_FULL_SCALE;
		end else if (!enabled) begin
			dim_config <= `RST_DIM_CONFIG;
			bl_enable <= 1'b0;
			ramp_hyst <= `RST_RAMP_HYST;
			bright_lsb <= `RST_BRIGHT_LSB;
			bright_msb <= `RST_BRIGHT_MSB;
			active_code <= 11'h7ff;
			sink_enable <= `RST_SINK_ENABLE;
			fb_disable <= `RST_FB_DISABLE;
			onoff_ramp <= `RST_ONOFF_RAMP;
			full_scale <= `RST_FULL_SCALE;
		end else if (wr) begin
			case (ADDR_I)
				`REG_BL_ENABLE: bl_enable <= WDATA_I[`BIT_BL_ON];
				`REG_DIM_CONFIG: dim_config <= WDATA_I;
				`REG_RAMP_HYST: ramp_hyst <= {1'b0, WDATA_I[6:0]};
				`REG_BRIGHT_LSB: bright_lsb <= {5'h00, WDATA_I[2:0]};
				`REG_BRIGHT_MSB: begin
					bright_msb <= WDATA_I;
					active_code <= {WDATA_I, bright_lsb[2:0]};
				end
				`REG_SINK_ENABLE: sink_enable <= WDATA_I;
				`REG_FB_DISABLE: fb_disable <= WDATA_I;
				`REG_ONOFF_RAMP: onoff_ramp <= WDATA_I;
				`REG_FULL_SCALE: full_scale <= {WDATA_I[7:3], 3'h0};
				default: begin
				end
			endcase
		end
	end

	always @* begin
		pwm_en = dim_config[`BIT_PWM_EN];
		onoff_shape = dim_config[`BIT_ONOFF_SHAPE];
		pwm_active_low = dim_config[`BIT_PWM_POL];
		map_linear = dim_config[`BIT_MAP_LINEAR];
	end

	// register reads, one cycle later
	always @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			RDATA_O <= 8'h00;
		end else if (rd) begin
			case (ADDR_I)
				`REG_BL_ENABLE: RDATA_O <= {7'h00, bl_enable};
				`REG_DIM_CONFIG: RDATA_O <= dim_config;
				`REG_RAMP_HYST: RDATA_O <= ramp_hyst;
				`REG_BRIGHT_LSB: RDATA_O <= bright_lsb;
				`REG_BRIGHT_MSB: RDATA_O <= bright_msb;
				`REG_SINK_ENABLE: RDATA_O <= sink_enable;
				`REG_FB_DISABLE: RDATA_O <= fb_disable;
				`REG_DUTY_LOW: RDATA_O <= duty[7:0];
				`REG_DUTY_HIGH: RDATA_O <= {5'h00, duty[10:8]};
				`REG_ONOFF_RAMP: RDATA_O <= onoff_ramp;
				`REG_FULL_SCALE: RDATA_O <= full_scale;
				`REG_STATUS: RDATA_O <= {5'h00, duty_seen, BOOST_ON_O, bl_wanted};
				default: RDATA_O <= 8'h00;
			endcase
		end else begin
			RDATA_O <= 8'h00;
		end
	end

	// grounded sink detection at start-up
	always @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			start_done <= 1'b0;
		end else if (!enabled || !bl_enable) begin
			start_done <= 1'b0;
		end else if (!start_done) begin
			start_done <= 1'b1;
		end
	end

	// per-sink comparator sync, grounded capture and drive
	genvar ch;
	generate
		for (ch = 0; ch < 8; ch = ch + 1) begin : g_sink
			always @(posedge CLOCK_I or posedge RESET_I) begin
				if (RESET_I) begin
					gnd_s1[ch] <= 1'b0;
					gnd_s2[ch] <= 1'b0;
				end else begin
					gnd_s1[ch] <= SINK_GROUNDED_I[ch];
					gnd_s2[ch] <= gnd_s1[ch];
				end
			end
			always @(posedge CLOCK_I or posedge RESET_I) begin
				if (RESET_I) begin
					grounded[ch] <= 1'b0;
				end else if (enabled && bl_enable && !start_done) begin
					grounded[ch] <= gnd_s2[ch];
				end
			end
			always @(posedge CLOCK_I or posedge RESET_I) begin
				if (RESET_I) begin
					SINK_ON_O[ch] <= 1'b0;
				end else begin
					SINK_ON_O[ch] <= enabled && (level != 11'h000) && sinks_use[ch];
				end
			end
		end
	endgenerate

	// duty measurement on the sampling clock
	always @* begin
		prod = {11'h000, hi_cnt} * {{(PERIOD_W-11){1'b0}}, `FULL_DUTY};
		next_duty = 11'h000;
		if (per_cnt != {PERIOD_W{1'b0}}) begin
			scaled = prod / {11'h000, per_cnt};
			next_duty = (scaled > {{PERIOD_W{1'b0}}, 11'h7ff}) ? 11'h7ff : scaled[10:0];
		end else begin
			scaled = {(PERIOD_W+11){1'b0}};
		end
	end

	always @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			hi_cnt <= {PERIOD_W{1'b0}};
			per_cnt <= {PERIOD_W{1'b0}};
			pwm_prev <= 1'b0;
			duty <= 11'h000;
			duty_seen <= 1'b0;
		end else if (!enabled || !pwm_en) begin
			hi_cnt <= {PERIOD_W{1'b0}};
			per_cnt <= {PERIOD_W{1'b0}};
			pwm_prev <= 1'b0;
			duty <= 11'h000;
			duty_seen <= 1'b0;
		end else begin
			pwm_prev <= pwm_level;
			if (pwm_rise) begin
				duty <= next_duty;
				duty_seen <= duty_seen | (next_duty != 11'h000);
				hi_cnt <= {{(PERIOD_W-1){1'b0}}, 1'b1};
				per_cnt <= {{(PERIOD_W-1){1'b0}}, 1'b1};
			end else if (&per_cnt) begin
				duty <= pwm_level ? `FULL_DUTY : 11'h000;
				per_cnt <= {PERIOD_W{1'b0}};
				hi_cnt <= {PERIOD_W{1'b0}};
			end else begin
				per_cnt <= per_cnt + {{(PERIOD_W-1){1'b0}}, 1'b1};
				hi_cnt <= hi_cnt + {{(PERIOD_W-1){1'b0}}, pwm_level};
			end
		end
	end

	// hysteresis on reversals
	always @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			duty_follow <= 11'h000;
			dir_up <= 1'b1;
		end else if (!enabled || !pwm_en) begin
			duty_follow <= 11'h000;
			dir_up <= 1'b1;
		end else if (duty > duty_follow) begin
			if (dir_up || ({1'b0, duty} - {1'b0, duty_follow} >= hyst_lsb)) begin
				duty_follow <= duty;
				dir_up <= 1'b1;
			end
		end else if (duty < duty_follow) begin
			if (!dir_up || ({1'b0, duty_follow} - {1'b0, duty} >= hyst_lsb)) begin
				duty_follow <= duty;
				dir_up <= 1'b0;
			end
		end
	end

	// brightness ramp toward target
	always @* begin
		target = bl_wanted ? code_now : 11'h000;
		if (target == level) begin
			step_cyc = 32'd1;
		end else if (!bl_wanted || level == 11'h000) begin
			step_cyc = ({28'h0, (bl_wanted ? onoff_ramp[7:4] : onoff_ramp[3:0])} + 32'd1)
				* `ONOFF_UNIT_CYC * STEP_SCALE / 32'd2047;
		end else begin
			step_cyc = ({28'h0, ramp_sel} + 32'd1) * ({28'h0, ramp_sel} + 32'd1)
				* `RAMP_UNIT_CYC * 32'd2500 * STEP_SCALE / 32'd2047;
		end
		if (step_cyc == 32'd0) begin
			step_cyc = 32'd1;
		end
	end

	always @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			level <= 11'h000;
			tick <= 32'd0;
		end else if (!enabled) begin
			level <= 11'h000;
			tick <= 32'd0;
		end else if (target == level) begin
			tick <= 32'd0;
		end else if (tick + 32'd1 >= step_cyc) begin
			tick <= 32'd0;
			level <= (target > level) ? level + 11'h001 : level - 11'h001;
		end else begin
			tick <= tick + 32'd1;
		end
	end

	// outputs: DC level, duty, boost, mapping, full scale
	always @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			BOOST_ON_O <= 1'b0;
			MAPPING_LINEAR_O <= 1'b0;
			FULL_SCALE_SINK_CURRENT_O <= 5'h00;
			LEVEL_CODE_O <= 11'h000;
			LEVEL_DUTY_O <= 11'h000;
		end else begin
			BOOST_ON_O <= enabled && level != 11'h000 && !(pwm_en && all_fb_off);
			MAPPING_LINEAR_O <= map_linear;
			FULL_SCALE_SINK_CURRENT_O <= full_scale[7:3];
			LEVEL_CODE_O <= level;
			LEVEL_DUTY_O <= pwm_en ? duty_follow : `FULL_DUTY;
		end
	end
endmodule // backlight_dimming_control

// >>> verif/backlight_dimming_control_chk.sv
// concurrent checks on the dimming control ports
`include "backlight_dimming_control_defs.vh"
module backlight_dimming_control_chk (
	input wire CLOCK_I,
	input wire RESET_I,
	input wire HARDWARE_ENABLE_PIN_I,
	input wire [7:0] SINK_GROUNDED_I,
	input wire [7:0] ADDR_I,
	input wire [7:0] WDATA_I,
	input wire WRITE_I,
	input wire READ_I,
	input wire [7:0] RDATA_O,
	input wire [7:0] SINK_ON_O,
	input wire BOOST_ON_O,
	input wire MAPPING_LINEAR_O,
	input wire [4:0] FULL_SCALE_SINK_CURRENT_O,
	input wire [10:0] LEVEL_CODE_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (RESET_I);
	logic [4:0] fs_q;
	logic map_q;
	// last accepted full-scale and mapping writes
	always @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			fs_q <= 5'h1f;
			map_q <= 1'b0;
		end else if (WRITE_I && HARDWARE_ENABLE_PIN_I) begin
			fs_q <= (ADDR_I == `REG_FULL_SCALE) ? WDATA_I[7:3] : fs_q;
			map_q <= (ADDR_I == `REG_DIM_CONFIG) ? WDATA_I[3] : map_q;
		end
	end
	sequence hw_on; HARDWARE_ENABLE_PIN_I [*4]; endsequence
	sequence hw_off; !HARDWARE_ENABLE_PIN_I [*4]; endsequence
	sequence fs_wr; hw_on ##0 (WRITE_I && ADDR_I == `REG_FULL_SCALE); endsequence
	sequence map_wr; hw_on ##0 (WRITE_I && ADDR_I == `REG_DIM_CONFIG); endsequence
	shut_cut_a: assert property ($fell(HARDWARE_ENABLE_PIN_I) |-> ##[1:4] LEVEL_CODE_O == 11'h000)
		else $error("level not cut after enable pin fell");
	shut_quiet_a: assert property (hw_off |-> RDATA_O == 8'h00 && SINK_ON_O == 8'h00 && !BOOST_ON_O)
		else $error("activity while enable pin low");
	rdata_idle_a: assert property (!READ_I |=> RDATA_O == 8'h00)
		else $error("read data without read strobe");
	ramp_step_a: assert property (hw_on |-> LEVEL_CODE_O == $past(LEVEL_CODE_O) ||
		LEVEL_CODE_O == $past(LEVEL_CODE_O) + 11'h001 || LEVEL_CODE_O + 11'h001 == $past(LEVEL_CODE_O))
		else $error("level jumped by more than one step");
	boost_sinks_a: assert property ($rose(BOOST_ON_O) |-> ##[0:2] SINK_ON_O != 8'h00)
		else $error("boost on with no sink enabled");
	ground_mask_a: assert property ($stable(SINK_GROUNDED_I) |-> (SINK_ON_O & SINK_GROUNDED_I) == 8'h00)
		else $error("grounded sink enabled");
	scale_write_a: assert property (fs_wr |-> ##2 FULL_SCALE_SINK_CURRENT_O == fs_q)
		else $error("full scale output does not follow write");
	map_write_a: assert property (map_wr |-> ##2 MAPPING_LINEAR_O == map_q)
		else $error("mapping output does not follow write");
endmodule // backlight_dimming_control_chk
bind backlight_dimming_control backlight_dimming_control_chk u_chk (.CLOCK_I(CLOCK_I),
	.RESET_I(RESET_I), .HARDWARE_ENABLE_PIN_I(HARDWARE_ENABLE_PIN_I),
	.SINK_GROUNDED_I(SINK_GROUNDED_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WRITE_I(WRITE_I),
	.READ_I(READ_I), .RDATA_O(RDATA_O), .SINK_ON_O(SINK_ON_O), .BOOST_ON_O(BOOST_ON_O),
	.MAPPING_LINEAR_O(MAPPING_LINEAR_O), .FULL_SCALE_SINK_CURRENT_O(FULL_SCALE_SINK_CURRENT_O),
	.LEVEL_CODE_O(LEVEL_CODE_O));

// >>> verif/pwm_source.sv
// host pwm source with programmable period and high time
module pwm_source (
	input wire clk_i,
	input wire [15:0] per_i,
	input wire [15:0] hi_i,
	output logic pwm_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cnt = 16'h0000;
	initial pwm_o = 1'b0;
	always @(posedge clk_i) begin
		cnt <= (cnt + 16'h0001 >= per_i) ? 16'h0000 : cnt + 16'h0001;
		pwm_o <= cnt < hi_i;
	end
endmodule // pwm_source

// >>> verif/backlight_dimming_control_tb.sv
// self-checking bench for the dimming control block
`include "backlight_dimming_control_defs.vh"
module backlight_dimming_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, hw = 0, wr = 0, rd = 0;
	logic [7:0] gnd = 8'h81, addr = 8'h00, wdata = 8'h00, rdata, sinks, v, r;
	logic boost, lin;
	logic [4:0] fs;
	logic [10:0] level, duty;
	logic [15:0] hi = 16'd0;
	wire pwm;
	int n_mismatch = 0, comparisons = 0;
	logic [15:0] dflt [8] = '{{`REG_BL_ENABLE, `RST_BL_ENABLE}, {`REG_DIM_CONFIG, `RST_DIM_CONFIG},
		{`REG_BRIGHT_LSB, `RST_BRIGHT_LSB}, {`REG_BRIGHT_MSB, `RST_BRIGHT_MSB},
		{`REG_SINK_ENABLE, `RST_SINK_ENABLE}, {`REG_ONOFF_RAMP, `RST_ONOFF_RAMP},
		{`REG_FULL_SCALE, `RST_FULL_SCALE}, {8'h7e, 8'h00}};
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
	$display("wrong value %s expected %0h seen %0h", n, e, a); end end
	always #25 clk = ~clk;
	pwm_source u_pwm_source (.clk_i(clk), .per_i(16'd200), .hi_i(hi), .pwm_o(pwm));
	backlight_dimming_control #(.PERIOD_W(12)) u_backlight_dimming_control (.CLOCK_I(clk),
		.RESET_I(rst), .HARDWARE_ENABLE_PIN_I(hw), .PWM_PIN_I(pwm), .SINK_GROUNDED_I(gnd),
		.ADDR_I(addr), .WDATA_I(wdata), .WRITE_I(wr), .READ_I(rd), .RDATA_O(rdata),
		.SINK_ON_O(sinks), .BOOST_ON_O(boost), .MAPPING_LINEAR_O(lin),
		.FULL_SCALE_SINK_CURRENT_O(fs), .LEVEL_CODE_O(level), .LEVEL_DUTY_O(duty));
	function bit near(input [10:0] a, input int e);
		return (int'(a) >= e - 3) && (int'(a) <= e + 3);
	endfunction
	function int dexp(input int h);
		return h * 2047 / 200;
	endfunction
	task wr_reg(input [7:0] a, input [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input [7:0] a, output [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task rd_chk(input [7:0] a, input [7:0] e);
		rd_reg(a, v);
		`CHK("rdata", e, v)
	endtask
	task wait_level(input [10:0] t);
		for (int k = 0; k < 40000 && level !== t; k++)
			@(negedge clk);
		`CHK("level", t, level)
	endtask
	task end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		end_sim;
	end
	initial begin
		r = 8'($urandom(80058));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		hw <= 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 8; i++)
			rd_chk(dflt[i][15:8], dflt[i][7:0]);
		$display("done register defaults");
		wr_reg(`REG_ONOFF_RAMP, 8'h00);
		wr_reg(`REG_BRIGHT_MSB, 8'h04);
		wr_reg(`REG_BL_ENABLE, 8'h01);
		wait_level(11'd39);
		`CHK("sinks", 8'hff & ~gnd, sinks)
		`CHK("boost", 1'b1, boost)
		wr_reg(`REG_SINK_ENABLE, 8'h3c);
		repeat (3) @(negedge clk);
		`CHK("sinks", 8'h3c & ~gnd, sinks)
		$display("done turn on");
		for (int i = 0; i < 4; i++) begin
			r = 8'($urandom);
			wr_reg(`REG_FULL_SCALE, r);
			wr_reg(`REG_DIM_CONFIG, {4'h0, r[3], 3'b010});
			repeat (3) @(negedge clk);
			`CHK("full scale", r[7:3], fs)
			`CHK("mapping", r[3], lin)
		end
		$display("done random settings");
		wr_reg(`REG_BRIGHT_LSB, 8'h00);
		repeat (50) @(negedge clk);
		`CHK("level", 11'd39, level)
		wr_reg(`REG_BRIGHT_MSB, 8'h0a);
		@(negedge clk);
		`CHK("ramping", 1'b1, level < 11'd45)
		wait_level(11'd80);
		$display("done brightness update");
		hi <= 16'd50;
		wr_reg(`REG_DIM_CONFIG, 8'h03);
		repeat (2000) @(negedge clk);
		`CHK("duty", 1'b1, near(duty, dexp(50)))
		rd_reg(`REG_DUTY_LOW, v);
		rd_reg(`REG_DUTY_HIGH, r);
		`CHK("duty readback", 1'b1, near({r[2:0], v}, dexp(50)))
		`CHK("boost", 1'b1, boost)
		wr_reg(`REG_RAMP_HYST, 8'h07);
		hi <= 16'd51;
		repeat (1000) @(negedge clk);
		@(posedge clk);
		hi <= 16'd50;
		repeat (1000) @(negedge clk);
		`CHK("duty hold", 1'b1, near(duty, dexp(51)))
		wr_reg(`REG_FB_DISABLE, 8'hff);
		repeat (3) @(negedge clk);
		`CHK("boost", 1'b0, boost)
		`CHK("sinks", 8'h3c, sinks)
		wr_reg(`REG_FB_DISABLE, 8'h00);
		wr_reg(`REG_DIM_CONFIG, 8'h07);
		repeat (2000) @(negedge clk);
		`CHK("duty", 1'b1, near(duty, dexp(150)))
		wr_reg(`REG_DIM_CONFIG, 8'h03);
		hi <= 16'd0;
		repeat (6000) @(negedge clk);
		`CHK("sinks", 8'h00, sinks)
		`CHK("boost", 1'b0, boost)
		wr_reg(`REG_DIM_CONFIG, 8'h02);
		wait_level(11'd80);
		`CHK("duty", `FULL_DUTY, duty)
		`CHK("boost", 1'b1, boost)
		$display("done pwm dimming");
		wr_reg(`REG_BL_ENABLE, 8'h00);
		repeat (3) @(negedge clk);
		`CHK("ramp down", 1'b1, level > 11'd60)
		wait_level(11'd0);
		rd_chk(`REG_BRIGHT_MSB, 8'h0a);
		$display("done software off");
		wr_reg(`REG_BL_ENABLE, 8'h01);
		wait_level(11'd80);
		@(posedge clk);
		hw <= 1'b0;
		repeat (5) @(negedge clk);
		`CHK("level", 11'd0, level)
		wr_reg(`REG_FULL_SCALE, 8'h10);
		rd_chk(`REG_FULL_SCALE, 8'h00);
		@(posedge clk);
		hw <= 1'b1;
		repeat (3) @(posedge clk);
		rd_chk(`REG_FULL_SCALE, `RST_FULL_SCALE);
		`CHK("full scale", `RST_FULL_SCALE >> 3, fs)
		$display("done enable pin off");
		end_sim;
	end
endmodule // backlight_dimming_control_tb
